// file: verilog/lepc_pkg.sv
// Constants shared by the energy-sense power control block.
// Assumes a 125 MHz system clock and a management port that reaches register 0x1d.
package lepc_pkg;

  // Register address and field positions.
  localparam logic [4:0] REG_ENERGY_SENSE_CONTROL = 5'h1d;
  localparam int         BIT_ENABLE              = 15;
  localparam int         BIT_AUTO_WAKE           = 14;
  localparam int         BIT_AUTO_SLEEP          = 13;
  localparam int         BIT_MANUAL_TOGGLE       = 12;
  localparam int         BIT_BURST_DISABLE       = 11;
  localparam int         BIT_POWER_STATE         = 10;
  localparam int         BIT_ERR_MET             = 9;
  localparam int         BIT_DATA_MET            = 8;
  localparam int         ERR_THR_LSB             = 4;
  localparam int         DATA_THR_LSB            = 0;

  // Reset values.
  localparam logic [3:0] THRESHOLD_RESET  = 4'h1;
  localparam logic       AUTO_WAKE_RESET  = 1'b1;
  localparam logic       AUTO_SLEEP_RESET = 1'b1;

  // Pulse burst length.
  localparam logic [2:0] BURST_PULSES = 3'h4;

  // Inactivity timeout: 2 s at 125 MHz.
  localparam longint CLK_HZ           = 125000000;
  localparam longint TIMEOUT_MS       = 2000;
  localparam longint TIMEOUT_CYCLES   = (TIMEOUT_MS * CLK_HZ) / 1000;

  // Power sequencer states, one-hot.
  typedef enum logic [3:0] {
    LEPC_DOWN     = 4'h1,
    LEPC_WAKING   = 4'h2,
    LEPC_UP       = 4'h4,
    LEPC_SLEEPING = 4'h8
  } lepc_state_t;

endpackage : lepc_pkg

// file: verilog/lepc_pulse_gen.sv
// Pulse generator for energy-sense data pulses sent when the line driver powers up.
// Assumes a one-cycle start pulse from the sequencer in the same clock domain.
`timescale 1ns/1ps
module lepc_pulse_gen (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Control.
  input  wire logic start,
  input  wire logic single,
  // Output.
  output logic      pulse_out,
  output logic      busy
);

  typedef struct packed {
    logic [2:0] left;
    logic       phase;
    logic       pulse;
  } lepc_pg_t;

  lepc_pg_t st;
  lepc_pg_t next_st;

  // Pulses alternate with idle cycles so each one is distinct on the line.
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (start) begin
      next_st.left  = single ? 3'h1 : lepc_pkg::BURST_PULSES;
      next_st.phase = 1'b0;
    end else if (st.left != 3'h0) begin
      if (!st.phase) begin
        next_st.pulse = 1'b1;
        next_st.left  = st.left - 3'h1;
      end
      next_st.phase = ~st.phase;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_out = st.pulse;
  assign busy      = (st.left != 3'h0);

endmodule : lepc_pulse_gen

// file: verilog/lepc_line_energy_power_control.sv
// Energy-sense power control: event counting, thresholds, power sequencer and control register.
// Assumes event inputs are one-cycle pulses synchronous to clk_sys and a simple
// management register port (address, write strobe, read strobe) driven by the serial interface.
//
// Behaviour
// - Energy-sense management acts only while the enable bit is set; resets to 0.
// - With auto wake set, reaching the activity threshold starts power up; resets to 1.
// - With auto sleep set, silence on the line starts power down; resets to 1.
// - Writing 1 to manual toggle changes power state regardless; bit self-clears.
// - On driver power-up send four pulses, or one when burst is disabled.
// - Read-only power state bit reads 1 when up, 0 when down.
// - Error threshold flag sets on error count met, no action, clears on read.
// - Activity flag sets when data count meets threshold, clears on read.
// - Error threshold is writable bits 7:4, reset 0001.
// - Activity threshold is writable bits 3:0, reset 0001.
// - Event counters clear after about 2 seconds without a data event.
`timescale 1ns/1ps
module lepc_line_energy_power_control #(
  parameter longint TIMEOUT_CYCLES = lepc_pkg::TIMEOUT_CYCLES,
  parameter int     TIMER_WIDTH    = 28
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Management register port.
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Line events from the analog sense path.
  input  wire logic        data_event,
  input  wire logic        error_event,
  input  wire logic        energy_present,
  // Power control toward the line driver.
  output logic             line_driver_power,
  output logic             sense_pulse
);

  typedef struct packed {
    logic                    enable;
    logic                    auto_wake;
    logic                    auto_sleep;
    logic                    manual;
    logic                    burst_dis;
    logic                    err_met;
    logic                    data_met;
    logic [3:0]              err_thr;
    logic [3:0]              data_thr;
    logic [3:0]              data_cnt;
    logic [3:0]              err_cnt;
    logic [TIMER_WIDTH-1:0]  timer;
    lepc_pkg::lepc_state_t   state;
    logic                    drv_on;
    logic                    pulse_start;
    logic [15:0]             rdata;
  } lepc_regs_t;

  lepc_regs_t r;
  lepc_regs_t next_r;

  logic pulse_out;

  localparam logic [TIMER_WIDTH-1:0] TIMER_LAST = TIMER_WIDTH'(TIMEOUT_CYCLES - 1);

  // Saturating four-bit increment shared by both event counters.
  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == 4'hf) ? v : v + 4'h1;
  endfunction : sat_inc

  // Register image as software reads it.
  function automatic logic [15:0] image(input lepc_regs_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[lepc_pkg::BIT_ENABLE]        = s.enable;
    w[lepc_pkg::BIT_AUTO_WAKE]     = s.auto_wake;
    w[lepc_pkg::BIT_AUTO_SLEEP]    = s.auto_sleep;
    w[lepc_pkg::BIT_MANUAL_TOGGLE] = s.manual;
    w[lepc_pkg::BIT_BURST_DISABLE] = s.burst_dis;
    w[lepc_pkg::BIT_POWER_STATE]   = (s.state == lepc_pkg::LEPC_UP) ||
                                     (s.state == lepc_pkg::LEPC_SLEEPING);
    w[lepc_pkg::BIT_ERR_MET]       = s.err_met;
    w[lepc_pkg::BIT_DATA_MET]      = s.data_met;
    w[lepc_pkg::ERR_THR_LSB +: 4]  = s.err_thr;
    w[lepc_pkg::DATA_THR_LSB +: 4] = s.data_thr;
    image = w;
  endfunction : image

  // Whole-block next-state logic.
  always_comb begin
    logic hit;
    logic data_reached;
    logic err_reached;
    logic go_toggle;
    hit          = (reg_addr == lepc_pkg::REG_ENERGY_SENSE_CONTROL);
    data_reached = 1'b0;
    err_reached  = 1'b0;
    go_toggle    = r.enable && r.manual;
    next_r       = r;
    next_r.pulse_start = 1'b0;

    // Read data is captured so the output comes from a flop; the read clears the sticky flags.
    if (reg_rd && hit) begin
      next_r.rdata = image(r);
    end else if (reg_rd) begin
      next_r.rdata = 16'h0000;
    end
    if (reg_rd && hit) begin
      next_r.err_met  = 1'b0;
      next_r.data_met = 1'b0;
    end

    // Manual toggle is consumed one cycle after it is written.
    next_r.manual = 1'b0;

    // Software writes; read-only bits ignore what is written there, and the self-clearing manual toggle takes the written value.
    if (reg_wr && hit) begin
      next_r.enable     = reg_wdata[lepc_pkg::BIT_ENABLE];
      next_r.auto_wake  = reg_wdata[lepc_pkg::BIT_AUTO_WAKE];
      next_r.auto_sleep = reg_wdata[lepc_pkg::BIT_AUTO_SLEEP];
      next_r.manual     = reg_wdata[lepc_pkg::BIT_MANUAL_TOGGLE];
      next_r.burst_dis  = reg_wdata[lepc_pkg::BIT_BURST_DISABLE];
      next_r.err_thr    = reg_wdata[lepc_pkg::ERR_THR_LSB +: 4];
      next_r.data_thr   = reg_wdata[lepc_pkg::DATA_THR_LSB +: 4];
    end

    // Event counters and inactivity timer only run while the function is enabled.
    if (r.enable) begin
      if (data_event) begin
        next_r.data_cnt = sat_inc(r.data_cnt);
        next_r.timer    = '0;
      end else if (r.timer == TIMER_LAST) begin
        next_r.data_cnt = 4'h0;
        next_r.err_cnt  = 4'h0;
        next_r.timer    = '0;
      end else begin
        next_r.timer = r.timer + TIMER_WIDTH'(1);
      end
      if (error_event) begin
        next_r.err_cnt = sat_inc(r.err_cnt);
      end
      // Flags set only on the event that meets the threshold, so a read can clear them while the count stays.
      data_reached = data_event && (next_r.data_cnt >= r.data_thr) && (next_r.data_cnt != 4'h0);
      err_reached  = error_event && (next_r.err_cnt >= r.err_thr) && (next_r.err_cnt != 4'h0);
      // Setting wins over a clear by read in the same cycle.
      if (data_reached) begin
        next_r.data_met = 1'b1;
      end
      if (err_reached) begin
        next_r.err_met = 1'b1;
      end
    end else begin
      next_r.data_cnt = 4'h0;
      next_r.err_cnt  = 4'h0;
      next_r.timer    = '0;
    end

    // Power sequencer; the waking and sleeping states let the driver settle for one cycle.
    case (r.state)
      lepc_pkg::LEPC_DOWN: begin
        if (go_toggle || (r.enable && r.auto_wake && data_reached)) begin
          next_r.state       = lepc_pkg::LEPC_WAKING;
          next_r.pulse_start = 1'b1;
          next_r.data_cnt    = 4'h0;
        end
      end
      lepc_pkg::LEPC_WAKING: begin
        next_r.state = lepc_pkg::LEPC_UP;
      end
      lepc_pkg::LEPC_UP: begin
        if (go_toggle || (r.enable && r.auto_sleep && !energy_present)) begin
          next_r.state = lepc_pkg::LEPC_SLEEPING;
        end
      end
      lepc_pkg::LEPC_SLEEPING: begin
        next_r.state = lepc_pkg::LEPC_DOWN;
      end
      default: begin
        next_r.state = lepc_pkg::LEPC_DOWN;
      end
    endcase
    // Disabling returns the sequencer to its idle, powered-up state.
    if (!r.enable) begin
      next_r.state = lepc_pkg::LEPC_UP;
    end
    // Driver power is registered from the next state so the pin comes straight from a flop.
    next_r.drv_on = (next_r.state == lepc_pkg::LEPC_UP) || (next_r.state == lepc_pkg::LEPC_WAKING);
  end

  // State register; controls take their documented reset values.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r            <= '0;
      r.auto_wake  <= lepc_pkg::AUTO_WAKE_RESET;
      r.auto_sleep <= lepc_pkg::AUTO_SLEEP_RESET;
      r.err_thr    <= lepc_pkg::THRESHOLD_RESET;
      r.data_thr   <= lepc_pkg::THRESHOLD_RESET;
      r.state      <= lepc_pkg::LEPC_UP;
      r.drv_on     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Pulse burst toward the line driver.
  lepc_pulse_gen u_pulse (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .start     (r.pulse_start),
    .single    (r.burst_dis),
    .pulse_out (pulse_out),
    .busy      ()
  );

  // Outputs come straight from flops.
  assign reg_rdata         = r.rdata;
  assign line_driver_power = r.drv_on;
  assign sense_pulse       = pulse_out;

endmodule : lepc_line_energy_power_control

// file: verif/lepc_link_peer.sv
// Link partner model: drives line events and the energy level.
// Assumes the bench calls its tasks; changes land at the falling edge.
`timescale 1ns/1ps
module lepc_link_peer (
  // Clock.
  input wire logic clk_sys,
  // Line side.
  output logic     data_event,
  output logic     error_event,
  output logic     energy_present
);
  // Quiet line with energy present from time zero.
  initial begin
    data_event = 1'b0;
    error_event = 1'b0;
    energy_present = 1'b1;
  end
  // One-cycle events with a gap, as the sense path reports them.
  task automatic send(input int n, input logic err);
    repeat (n) begin
      @(negedge clk_sys);
      data_event <= !err;
      error_event <= err;
      @(negedge clk_sys);
      data_event <= 1'b0;
      error_event <= 1'b0;
    end
  endtask : send
  // Energy on the cable.
  task automatic energy(input logic on);
    @(negedge clk_sys);
    energy_present <= on;
  endtask : energy
endmodule : lepc_link_peer

// file: verif/lepc_monitor.sv
// Port checker for the energy-sense power control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lepc_monitor (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Register port.
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Line and driver.
  input wire logic        data_event,
  input wire logic        error_event,
  input wire logic        line_driver_power,
  input wire logic        sense_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [2:0] pulse_cnt;
  // Pulses since power-up; saturates so a runaway burst stays visible.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pulse_cnt <= 3'h0;
    else if ($rose(line_driver_power)) pulse_cnt <= 3'h0;
    else if (sense_pulse && pulse_cnt != 3'h7) pulse_cnt <= pulse_cnt + 3'h1;
  end
  sequence ctl_read;
    reg_rd && reg_addr == 5'h1d;
  endsequence
  // An event in the read cycle or the one after may legally set a flag again, so demand a quiet line.
  sequence quiet_line;
    !data_event && !error_event;
  endsequence
  sequence quiet_read;
    ctl_read ##0 quiet_line;
  endsequence
  unmapped_read_a: assert property (reg_rd && reg_addr != 5'h1d |=> reg_rdata == 16'h0000)
    else $error("unmapped read gave data");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  flag_clear_a: assert property (quiet_read ##1 quiet_line ##1 ctl_read |=> reg_rdata[9:8] == 2'b00)
    else $error("met flags survived a read");
  toggle_clear_a: assert property (ctl_read ##0 !$past(reg_wr) |=> !reg_rdata[12])
    else $error("manual toggle did not clear");
  disabled_up_a: assert property (ctl_read |=> !reg_rdata[15] |-> ##1 line_driver_power)
    else $error("driver off while disabled");
  pulse_gap_a: assert property (sense_pulse |=> !sense_pulse)
    else $error("pulses not separated");
  pulse_powered_a: assert property (sense_pulse |-> line_driver_power)
    else $error("pulse with driver off");
  burst_limit_a: assert property (pulse_cnt <= 3'h4)
    else $error("too many pulses in a burst");
endmodule : lepc_monitor

bind lepc_line_energy_power_control lepc_monitor i_mon (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_event(data_event), .error_event(error_event),
  .line_driver_power(line_driver_power), .sense_pulse(sense_pulse));

// file: verif/lepc_line_energy_power_control_tb.sv
// Self-checking bench for the energy-sense power control.
// Assumes the link peer model drives the line; timeout shortened to 50 cycles.
`timescale 1ns/1ps
module lepc_line_energy_power_control_tb;
  logic        clk_sys, arst_n, reg_wr, reg_rd, rd_seen, ldp, sense_pulse, data_event, error_event, energy_present;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cfg;
  logic [31:0] exp_q[$], note;
  int          errors, samples_checked, pulses;
  lepc_line_energy_power_control #(.TIMEOUT_CYCLES(50)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_event(data_event), .error_event(error_event), .energy_present(energy_present),
    .line_driver_power(ldp), .sense_pulse(sense_pulse));
  lepc_link_peer i_peer (.clk_sys(clk_sys), .data_event(data_event), .error_event(error_event),
    .energy_present(energy_present));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [15:0] d, input logic [4:0] a = 5'h1d);
    @(negedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // The note goes in before the read so the watcher always finds it.
  task automatic rd(input logic [15:0] m, input logic [15:0] v, input logic [4:0] a = 5'h1d);
    @(negedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({m, v & m});
    @(negedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wait_ldp(input logic v);
    int i;
    for (i = 0; i < 200 && ldp !== v; i++) @(negedge clk_sys);
    check("line_driver_power", {15'h0, ldp}, {15'h0, v});
    if (i == 200) give_verdict();
  endtask : wait_ldp
  // Read data is registered, so it is compared one falling edge after the read edge.
  always @(posedge clk_sys) rd_seen <= reg_rd;
  // Pulses are counted at the falling edge, where the registered output has settled.
  always @(negedge clk_sys) if (sense_pulse === 1'b1) pulses++;
  always @(negedge clk_sys) if (rd_seen === 1'b1) begin
    note = exp_q.pop_front();
    check("reg_rdata", reg_rdata & note[31:16], note[15:0]);
  end
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h1d;
    reg_wdata = 16'h0000;
    void'($urandom(55));
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    rd(16'hfbff, 16'h6011);
    $display("test reset done");
    cfg = 16'h6700 | 16'($urandom() & 32'h0000_00ff);
    wr(cfg);
    wr(16'hffff, 5'h1c);
    rd(16'hffff, 16'h0000, 5'h1e);
    i_peer.send(3, 1'b0);
    repeat (4) @(negedge clk_sys);
    rd(16'hfbff, cfg & 16'h60ff);
    rd(16'hfbff, cfg & 16'h60ff);
    $display("test disabled done");
    wr(16'he032);
    rd(16'hffff, 16'he432);
    i_peer.send(1, 1'b0);
    rd(16'hffff, 16'he432);
    i_peer.send(1, 1'b0);
    rd(16'hffff, 16'he532);
    rd(16'hffff, 16'he432);
    i_peer.send(3, 1'b1);
    rd(16'hffff, 16'he632);
    check("line_driver_power", {15'h0, ldp}, 16'h0001);
    $display("test thresholds done");
    repeat (60) @(negedge clk_sys);
    i_peer.energy(1'b0);
    wait_ldp(1'b0);
    rd(16'h0400, 16'h0000);
    pulses = 0;
    i_peer.energy(1'b1);
    i_peer.send(1, 1'b0);
    check("line_driver_power", {15'h0, ldp}, 16'h0000);
    i_peer.send(1, 1'b0);
    wait_ldp(1'b1);
    repeat (20) @(negedge clk_sys);
    check("pulses", pulses[15:0], 16'h0004);
    rd(16'h0400, 16'h0400);
    $display("test auto power done");
    wr(16'he832);
    i_peer.energy(1'b0);
    wait_ldp(1'b0);
    i_peer.energy(1'b1);
    rd(16'h0800, 16'h0800);
    pulses = 0;
    wr(16'hf832);
    wait_ldp(1'b1);
    repeat (20) @(negedge clk_sys);
    check("pulses", pulses[15:0], 16'h0001);
    rd(16'h1000, 16'h0000);
    wr(16'hf832);
    wait_ldp(1'b0);
    $display("test manual done");
    i_peer.send(1, 1'b0);
    repeat (80) @(negedge clk_sys);
    i_peer.send(1, 1'b0);
    repeat (4) @(negedge clk_sys);
    check("line_driver_power", {15'h0, ldp}, 16'h0000);
    rd(16'h0100, 16'h0000);
    i_peer.send(1, 1'b0);
    wait_ldp(1'b1);
    $display("test timeout done");
    give_verdict();
  end
endmodule : lepc_line_energy_power_control_tb
